// [fail_safe_output_control.sv]
// Operation
// - Fail-safe pin is active-low open drain: pulled low when active, else released.
// - Battery below minimum fail level: output never activated, stays released.
// - Output off in init mode unless an SPI activation is still held; init time-out expiry activates it.
// - Normal mode: trip on first watchdog failure (config 1/2), second (config 3/4).
// - Normal mode: off unless SPI-set or still latched awaiting watchdog then SPI clear.
// - Restart mode: reset pin shorted high/low or supply time-out activates output.
// - SPI activation held in every mode except off; regulator thermal shutdown activates output.
// - SPI-activated output is released only by a later SPI deactivation or by off mode.
// - Fault activation released in normal mode only after watchdog trigger then SPI off, else only on entering off or init.
// - Watchdog trigger alone keeps output active until SPI deactivation arrives.
// - Supply time-out: low supply with battery high, both held beyond time-out period.
// - Supply time-out enters fail-safe and activates output if battery above minimum.
// - Strap grounded selects software development mode; open or high selects normal.
// - Strap pull-up enabled only in init mode.
// - Strap sampled through init; development mode only if low the whole time.
// - Development mode held while battery above switch-off; left only through off.
module fail_safe_output_control
    import fail_safe_pkg::*;
#(
    parameter int INIT_TIMEOUT_COUNT = INIT_TIMEOUT_CYCLES,
    parameter int MCU_UV_COUNT       = MCU_UV_TIMEOUT_CYCLES
)
(
    input  wire logic      core_clk,
    input  wire logic      sys_rst,
    input  wire sbc_mode_t sbcMode,
    input  wire logic      batteryAboveFailMin,
    input  wire logic      batteryAbovePowerOn,
    input  wire logic      batteryAboveSwitchOff,
    input  wire logic      batteryAboveUvTimeoutThr,
    input  wire logic      mcuSupplyBelowReset,
    input  wire logic      configSelect34,
    input  wire logic      watchdogFail,
    input  wire logic      watchdogTriggerOk,
    input  wire logic      spiFailOutputOn,
    input  wire logic      spiFailOutputOff,
    input  wire logic      resetShortHigh,
    input  wire logic      resetShortLow,
    input  wire logic      mcuSupplyThermalShutdown,
    input  wire logic      testStrapIn,
    output logic           failOutputOut,
    output logic           failOutputOe_n,
    output logic           testStrapPullUp,
    output logic           initTimeoutExpired,
    output logic           mcuSupplyUvTimeout,
    output logic           enterFailSafeReq,
    output logic           softwareDevelopmentMode
);

    // Refused at elaboration: a zero count would wrap the threshold to the largest timer value
    if (INIT_TIMEOUT_COUNT < 1 || MCU_UV_COUNT < 1)
    begin
        $error("Time-out counts must be at least one cycle");
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    wire logic inInit     = (sbcMode == MODE_INIT);
    wire logic inNormal   = (sbcMode == MODE_NORMAL);
    wire logic inRestart  = (sbcMode == MODE_RESTART);
    wire logic inFailSafe = (sbcMode == MODE_FAILSAFE);
    wire logic inOff      = (sbcMode == MODE_OFF);

    // ****************************************************************
    // Init time-out
    // ****************************************************************
    logic [TIMER_WIDTH-1:0] initTimer;
    wire logic              initTimerDone = (initTimer >= TIMER_WIDTH'(INIT_TIMEOUT_COUNT - 1));

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            initTimer <= '0;
        else if (!inInit)
            initTimer <= '0;
        else if (!initTimerDone)
            initTimer <= initTimer + TIMER_WIDTH'(1);
    end

    // Single pulse as the init time runs out
    logic initDoneSeen;
    wire logic initTimeoutEvent = inInit && initTimerDone && !initDoneSeen;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            initDoneSeen <= 1'b0;
        else
            initDoneSeen <= inInit && initTimerDone;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            initTimeoutExpired <= 1'b0;
        else
            initTimeoutExpired <= initTimeoutEvent;
    end

    // ****************************************************************
    // Microcontroller supply undervoltage time-out
    // ****************************************************************
    wire logic              uvCondition = mcuSupplyBelowReset && batteryAboveUvTimeoutThr;
    logic [TIMER_WIDTH-1:0] uvTimer;
    wire logic              uvTimerDone = (uvTimer >= TIMER_WIDTH'(MCU_UV_COUNT - 1));
    logic                   uvSeen;
    wire logic              uvEvent     = uvCondition && uvTimerDone && !uvSeen;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            uvTimer <= '0;
        else if (!uvCondition)
            uvTimer <= '0;
        else if (!uvTimerDone)
            uvTimer <= uvTimer + TIMER_WIDTH'(1);
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            uvSeen <= 1'b0;
        else
            uvSeen <= uvCondition && uvTimerDone;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            mcuSupplyUvTimeout <= 1'b0;
        else
            mcuSupplyUvTimeout <= uvEvent;
    end

    // Mode controller acts on this only when the output can really be driven
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            enterFailSafeReq <= 1'b0;
        else
            enterFailSafeReq <= uvEvent && batteryAboveFailMin;
    end

    // ****************************************************************
    // Watchdog failure counting in normal mode
    // ****************************************************************
    logic [1:0] wdFailCount;
    wire logic [1:0] wdFailLimit = configSelect34 ? WD_FAILS_CFG34 : WD_FAILS_CFG12;
    wire logic [1:0] wdFailNext  = wdFailCount + 2'h1;
    wire logic       wdTrip      = inNormal && watchdogFail && (wdFailNext >= wdFailLimit);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wdFailCount <= 2'h0;
        else if (!inNormal || watchdogTriggerOk)
            wdFailCount <= 2'h0;
        else if (watchdogFail && !wdTrip)
            wdFailCount <= wdFailNext;
    end

    // ****************************************************************
    // Activation causes
    // ****************************************************************
    wire logic restartFault = inRestart && (resetShortHigh || resetShortLow || uvEvent);
    wire logic faultEvent   = initTimeoutEvent || wdTrip || restartFault
                           || mcuSupplyThermalShutdown || uvEvent || inFailSafe;
    wire logic spiOnEvent   = inNormal && spiFailOutputOn;

    // ****************************************************************
    // Latches: SPI-set and fault-set are held separately
    // ****************************************************************
    logic spiLatched;
    logic faultLatched;
    logic wdReleaseArmed;

    // Release by SPI; a fresh request wins over the clear
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            spiLatched <= 1'b0;
        else if (inOff)
            spiLatched <= 1'b0;
        else if (spiOnEvent)
            spiLatched <= 1'b1;
        else if (spiFailOutputOff)
            spiLatched <= 1'b0;
    end

    // Armed by a good watchdog trigger in normal mode, consumed by SPI off
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wdReleaseArmed <= 1'b0;
        else if (!inNormal || faultEvent || !faultLatched)
            wdReleaseArmed <= 1'b0;
        else if (watchdogTriggerOk)
            wdReleaseArmed <= 1'b1;
    end

    wire logic faultRelease = inNormal && wdReleaseArmed && spiFailOutputOff;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            faultLatched <= 1'b0;
        // Once the init timer has run out the latch must survive the rest of init
        else if (inOff || (inInit && !initTimerDone))
            faultLatched <= 1'b0;
        else if (faultEvent)
            faultLatched <= 1'b1;
        else if (faultRelease)
            faultLatched <= 1'b0;
    end

    // ****************************************************************
    // Open-drain stage, driven low only when battery is high enough
    // ****************************************************************
    wire logic outputWanted = spiLatched || faultLatched;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            failOutputOe_n <= 1'b1;
        else
            failOutputOe_n <= !(outputWanted && batteryAboveFailMin);
    end

    assign failOutputOut = 1'b0;

    // ****************************************************************
    // Test strap: pull-up, sampling, stored development mode
    // ****************************************************************
    assign testStrapPullUp = inInit;

    logic strapLowThroughout;
    logic initSeen;
    logic initDoneGate;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            strapLowThroughout <= 1'b1;
        else if (!batteryAbovePowerOn && !initSeen)
            strapLowThroughout <= 1'b1;
        else if (inInit && testStrapIn)
            strapLowThroughout <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            initSeen <= 1'b0;
        else if (inOff || !batteryAboveSwitchOff)
            initSeen <= 1'b0;
        else if (inInit)
            initSeen <= 1'b1;
    end

    // Decided once as init ends; kept until the chip passes through off or battery falls below switch-off
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            softwareDevelopmentMode <= 1'b0;
        else if (inOff || !batteryAboveSwitchOff)
            softwareDevelopmentMode <= 1'b0;
        else if (initSeen && !inInit && initDoneGate)
            softwareDevelopmentMode <= strapLowThroughout;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            initDoneGate <= 1'b0;
        else
            initDoneGate <= inInit;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence seqTrip;
        faultEvent && batteryAboveFailMin && !inOff && !(inInit && !initTimerDone);
    endsequence

    sequence seqSpiSet;
        inNormal && spiFailOutputOn ##1 batteryAboveFailMin;
    endsequence

    sequence seqShort;
        inRestart && (resetShortHigh || resetShortLow) ##1 batteryAboveFailMin;
    endsequence

    sequence seqRelease;
        inNormal && watchdogTriggerOk && faultLatched && !faultEvent
        ##1 inNormal && spiFailOutputOff && !faultEvent;
    endsequence

    AST_LOW_BATTERY_RELEASED: assert property (@(posedge core_clk) disable iff (sys_rst)
        !batteryAboveFailMin |=> failOutputOe_n)
        else $error("Output driven with battery below minimum");
    AST_INIT_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
        inInit && !spiLatched && !initTimerDone |=> failOutputOe_n)
        else $error("Output driven in init without time-out");
    AST_INIT_TIMEOUT: assert property (@(posedge core_clk) disable iff (sys_rst)
        initTimeoutEvent && batteryAboveFailMin |=> ##1 (!failOutputOe_n || !batteryAboveFailMin))
        else $error("Init time-out did not activate output");
    AST_WD_TRIP: assert property (@(posedge core_clk) disable iff (sys_rst)
        inNormal && watchdogFail && !configSelect34 && !watchdogTriggerOk |-> wdTrip)
        else $error("First watchdog failure did not trip in config 1/2");
    AST_FAULT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        seqTrip |=> faultLatched)
        else $error("Fault cause did not latch output");
    AST_WD_ALONE: assert property (@(posedge core_clk) disable iff (sys_rst)
        faultLatched && !spiFailOutputOff && !inOff && !inInit |=> faultLatched)
        else $error("Fault output released without SPI deactivation");
    AST_SPI_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        spiLatched && !spiFailOutputOff && !inOff |=> spiLatched)
        else $error("SPI activation lost without SPI off");
    AST_PULLUP: assert property (@(posedge core_clk) disable iff (sys_rst)
        testStrapPullUp == inInit)
        else $error("Strap pull-up outside init");
    AST_UV_FAILSAFE: assert property (@(posedge core_clk) disable iff (sys_rst)
        uvEvent && batteryAboveFailMin |=> enterFailSafeReq && mcuSupplyUvTimeout)
        else $error("Supply time-out did not request fail-safe");
    AST_STRAP_HIGH: assert property (@(posedge core_clk) disable iff (sys_rst)
        inInit && testStrapIn |=> !strapLowThroughout)
        else $error("High strap did not cancel development mode");
    AST_INIT_HELD: assert property (@(posedge core_clk) disable iff (sys_rst)
        inInit && initTimerDone && faultLatched |=> faultLatched)
        else $error("Init time-out activation dropped while still in init");
    AST_SPI_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
        seqSpiSet |=> !failOutputOe_n)
        else $error("SPI activation in normal mode did not drive output");
    AST_SPI_IGNORED: assert property (@(posedge core_clk) disable iff (sys_rst)
        !inNormal && spiFailOutputOn && !spiLatched |=> !spiLatched)
        else $error("SPI activation accepted outside normal mode");
    AST_CFG34_SECOND: assert property (@(posedge core_clk) disable iff (sys_rst)
        inNormal && watchdogFail && configSelect34 && (wdFailCount != 2'h0) |-> wdTrip)
        else $error("Second watchdog failure did not trip in config 3/4");
    AST_RESTART_SHORT: assert property (@(posedge core_clk) disable iff (sys_rst)
        seqShort |=> !failOutputOe_n)
        else $error("Reset short in restart did not activate output");
    AST_FAULT_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
        seqRelease |=> !faultLatched)
        else $error("Watchdog trigger then SPI off did not release fault");
    AST_UV_NEEDS_CONDITION: assert property (@(posedge core_clk) disable iff (sys_rst)
        !uvCondition |=> !mcuSupplyUvTimeout)
        else $error("Supply time-out without its condition");
    AST_FAILSAFE_ON: assert property (@(posedge core_clk) disable iff (sys_rst)
        inFailSafe ##1 batteryAboveFailMin |=> !failOutputOe_n)
        else $error("Output not driven in fail-safe mode");

endmodule

// [fail_safe_output_control_tb.sv]
module fail_safe_output_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fail_safe_pkg::*;

    localparam int INIT_CNT = 20;
    localparam int UV_CNT   = 30;
    localparam int WD_FAIL  = 0;
    localparam int WD_OK    = 1;
    localparam int SPI_ON   = 2;
    localparam int SPI_OFF  = 3;

    logic      core_clk, sys_rst, strapGrounded, failPin, testStrapIn;
    sbc_mode_t sbcMode;
    logic      batteryAboveFailMin, batteryAbovePowerOn, batteryAboveSwitchOff, batteryAboveUvTimeoutThr;
    logic      mcuSupplyBelowReset, configSelect34, watchdogFail, watchdogTriggerOk;
    logic      spiFailOutputOn, spiFailOutputOff, resetShortHigh, resetShortLow, mcuSupplyThermalShutdown;
    logic      failOutputOut, failOutputOe_n, testStrapPullUp, initTimeoutExpired;
    logic      mcuSupplyUvTimeout, enterFailSafeReq, softwareDevelopmentMode;
    int        mismatches  = 0;
    int        checks_done = 0;
    sbc_mode_t holdModes[4] = '{MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_REPROG};

    fail_safe_output_control #(.INIT_TIMEOUT_COUNT(INIT_CNT), .MCU_UV_COUNT(UV_CNT)) dut
    (
        .core_clk, .sys_rst, .sbcMode, .batteryAboveFailMin, .batteryAbovePowerOn, .batteryAboveSwitchOff,
        .batteryAboveUvTimeoutThr, .mcuSupplyBelowReset, .configSelect34, .watchdogFail, .watchdogTriggerOk,
        .spiFailOutputOn, .spiFailOutputOff, .resetShortHigh, .resetShortLow, .mcuSupplyThermalShutdown,
        .testStrapIn, .failOutputOut, .failOutputOe_n, .testStrapPullUp, .initTimeoutExpired,
        .mcuSupplyUvTimeout, .enterFailSafeReq, .softwareDevelopmentMode
    );

    fail_safe_pin_model pins
    (
        .core_clk, .failOutputOut, .failOutputOe_n, .testStrapPullUp, .strapGrounded, .failPin, .testStrapIn
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic int trip_after(input int cfg);
        return (cfg != 0) ? 2 : 1;
    endfunction

    // The time-out counters may finish from one edge before to two edges after the nominal count
    function automatic logic near(input int n, input int target);
        return (n >= target - 1) && (n <= target + 2);
    endfunction

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic expect_on(input logic on);
        check(32'(failOutputOe_n), 32'(!on));
        check(32'(failPin), 32'(!on));
    endtask

    // One-cycle command, then the output state four edges later
    task automatic step(input int which, input logic on);
        case (which)
            WD_FAIL: watchdogFail = 1'b1;
            WD_OK:   watchdogTriggerOk = 1'b1;
            SPI_ON:  spiFailOutputOn = 1'b1;
            default: spiFailOutputOff = 1'b1;
        endcase
        tick(1);
        {watchdogFail, watchdogTriggerOk, spiFailOutputOn, spiFailOutputOff} = 4'h0;
        tick(3);
        expect_on(on);
    endtask

    task automatic release_fault;
        sbcMode = MODE_NORMAL;
        tick(2);
        step(SPI_OFF, 1'b1);
        step(WD_OK, 1'b1);
        step(SPI_OFF, 1'b0);
    endtask

    task automatic wait_pulse(input int which, output int n);
        n = 0;
        while (((which == 0) ? initTimeoutExpired : mcuSupplyUvTimeout) !== 1'b1)
        begin
            n++;
            if (n > 200)
            begin
                mismatches++;
                stop_test();
            end
            tick(1);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        int n;
        int seedVal;
        seedVal = $urandom(32'h37892B36);
        sys_rst = 1'b1;
        sbcMode = MODE_OFF;
        {batteryAboveFailMin, batteryAbovePowerOn, batteryAboveSwitchOff, batteryAboveUvTimeoutThr} = 4'hF;
        {mcuSupplyBelowReset, configSelect34, watchdogFail, watchdogTriggerOk} = 4'h0;
        {spiFailOutputOn, spiFailOutputOff, resetShortHigh, resetShortLow} = 4'h0;
        {mcuSupplyThermalShutdown, strapGrounded} = 2'h0;
        repeat (4) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        expect_on(1'b0);
        check(32'(failOutputOut), 32'h0);
        strapGrounded = 1'b1;
        sbcMode = MODE_INIT;
        tick(3);
        check(32'(testStrapPullUp), 32'h1);
        tick(5);
        sbcMode = MODE_NORMAL;
        strapGrounded = 1'b0;
        tick(3);
        check(32'(softwareDevelopmentMode), 32'h1);
        check(32'(testStrapPullUp), 32'h0);
        tick(3 + $urandom % 8);
        check(32'(softwareDevelopmentMode), 32'h1);
        batteryAboveSwitchOff = 1'b0;
        tick(3);
        check(32'(softwareDevelopmentMode), 32'h0);
        batteryAboveSwitchOff = 1'b1;
        sbcMode = MODE_INIT;
        strapGrounded = 1'b1;
        tick(4);
        strapGrounded = 1'b0;
        tick(1);
        strapGrounded = 1'b1;
        tick(4);
        sbcMode = MODE_NORMAL;
        tick(3);
        check(32'(softwareDevelopmentMode), 32'h0);
        strapGrounded = 1'b0;
        sbcMode = MODE_OFF;
        tick(2);
        sbcMode = MODE_INIT;
        tick(5);
        expect_on(1'b0);
        wait_pulse(0, n);
        check(32'(near(n + 5, INIT_CNT)), 32'h1);
        tick(2);
        expect_on(1'b1);
        check(32'(initTimeoutExpired), 32'h0);
        sbcMode = MODE_RESTART;
        tick(2);
        release_fault();
        for (int cfg = 0; cfg < 2; cfg++)
        begin
            sbcMode = MODE_OFF;
            configSelect34 = cfg[0];
            tick(2);
            sbcMode = MODE_NORMAL;
            tick(2 + $urandom % 4);
            for (int k = 1; k <= trip_after(cfg); k++)
                step(WD_FAIL, k == trip_after(cfg));
            release_fault();
        end
        sbcMode = holdModes[$urandom % 4];
        step(SPI_ON, 1'b0);
        sbcMode = MODE_NORMAL;
        step(SPI_ON, 1'b1);
        foreach (holdModes[k])
        begin
            sbcMode = holdModes[k];
            tick(2 + $urandom % 4);
            expect_on(1'b1);
        end
        sbcMode = MODE_NORMAL;
        step(WD_OK, 1'b1);
        step(SPI_OFF, 1'b0);
        batteryAboveFailMin = 1'b0;
        step(SPI_ON, 1'b0);
        step(SPI_OFF, 1'b0);
        batteryAboveFailMin = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            sbcMode = MODE_OFF;
            tick(2);
            sbcMode = (k == 3) ? MODE_FAILSAFE : MODE_RESTART;
            tick(1 + $urandom % 4);
            {resetShortHigh, resetShortLow, mcuSupplyThermalShutdown} = 3'(4 >> k);
            tick(3);
            expect_on(1'b1);
            {resetShortHigh, resetShortLow, mcuSupplyThermalShutdown} = 3'h0;
            release_fault();
        end
        sbcMode = MODE_RESTART;
        mcuSupplyBelowReset = 1'b1;
        batteryAboveUvTimeoutThr = 1'b0;
        tick(UV_CNT + 10);
        expect_on(1'b0);
        batteryAboveUvTimeoutThr = 1'b1;
        tick(UV_CNT - 10);
        mcuSupplyBelowReset = 1'b0;
        tick(1);
        mcuSupplyBelowReset = 1'b1;
        wait_pulse(1, n);
        check(32'(near(n, UV_CNT)), 32'h1);
        check(32'(enterFailSafeReq), 32'h1);
        mcuSupplyBelowReset = 1'b0;
        tick(2);
        expect_on(1'b1);
        check(32'(mcuSupplyUvTimeout), 32'h0);
        release_fault();
        stop_test();
    end
endmodule

// [fail_safe_pin_model.sv]
module fail_safe_pin_model
(
    input  wire logic core_clk,
    input  wire logic failOutputOut,
    input  wire logic failOutputOe_n,
    input  wire logic testStrapPullUp,
    input  wire logic strapGrounded,
    output logic      failPin,
    output logic      testStrapIn
);
    timeunit 1ns;
    timeprecision 1ps;

    logic floatBit;

    // ****************************************************************
    // Board side: pull-up on the output, strap wire to ground or open
    // ****************************************************************
    assign failPin = failOutputOe_n ? 1'b1 : failOutputOut;
    // An open strap with the pull-up off floats, so it must not read as a steady level
    assign testStrapIn = strapGrounded ? 1'b0 : (testStrapPullUp ? 1'b1 : floatBit);

    initial floatBit = 1'b0;

    always @(posedge core_clk)
    begin
        floatBit <= ~floatBit;
    end
endmodule

// [fail_safe_pkg.sv]
package fail_safe_pkg;

    // ****************************************************************
    // Operating modes of the chip, as reported by the mode controller
    // ****************************************************************
    typedef enum logic [2:0]
    {
        MODE_OFF      = 3'b000,
        MODE_INIT     = 3'b001,
        MODE_NORMAL   = 3'b010,
        MODE_STOP     = 3'b011,
        MODE_SLEEP    = 3'b100,
        MODE_RESTART  = 3'b101,
        MODE_FAILSAFE = 3'b110,
        MODE_REPROG   = 3'b111
    } sbc_mode_t;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS             = 20;
    localparam int INIT_TIMEOUT_PERIOD_MS    = 256;
    localparam int MCU_UV_TIMEOUT_PERIOD_MS  = 1024;
    localparam int NS_PER_MS                 = 1000000;
    localparam int INIT_TIMEOUT_CYCLES       = (INIT_TIMEOUT_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS));
    localparam int MCU_UV_TIMEOUT_CYCLES     = (MCU_UV_TIMEOUT_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS));

    // ****************************************************************
    // Watchdog failure counts that trip the output, per configuration, and the timer width
    // ****************************************************************
    localparam logic [1:0] WD_FAILS_CFG12    = 2'h1;
    localparam logic [1:0] WD_FAILS_CFG34    = 2'h2;
    localparam int         TIMER_WIDTH       = 32;

endpackage
